/* shared/uart_pkg.sv */
// Constants, field positions and state types for one UART channel.
// Assumes a single clock domain and a 16x baud tick from outside.
package uart_pkg;

	localparam int unsigned ADDR_W    = 3;
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned PTR_W     = 4;
	localparam int unsigned CNT_W     = 5;

	////////////////////////////////////////////////////////////////////////
	// Register addresses in the general register set
	localparam logic [2:0] ADDR_HOLDING    = 3'h0;
	localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h1;
	localparam logic [2:0] ADDR_LINE_STATE = 3'h5;

	////////////////////////////////////////////////////////////////////////
	// Interrupt enable register
	localparam int unsigned IE_RX    = 0;
	localparam int unsigned IE_TX    = 1;
	localparam int unsigned IE_LINE  = 2;
	localparam int unsigned IE_MODEM = 3;
	localparam logic [7:0]  IRQ_ENABLE_MASK  = 8'h0F;
	localparam logic [7:0]  IRQ_ENABLE_RESET = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Line state register; error field holds bits 4:1
	localparam int unsigned LS_DATA_READY = 0;
	localparam int unsigned LS_ERR_LSB    = 1;
	localparam int unsigned LS_ERR_MSB    = 4;
	localparam int unsigned LS_HOLD_EMPTY = 5;
	localparam int unsigned LS_TX_IDLE    = 6;
	localparam int unsigned LS_FIFO_ERR   = 7;
	localparam int unsigned ERR_OVERRUN   = 0;
	localparam int unsigned ERR_PARITY    = 1;
	localparam int unsigned ERR_FRAMING   = 2;
	localparam int unsigned ERR_BREAK     = 3;
	localparam logic [7:0]  LINE_STATE_RESET = 8'h60;

	////////////////////////////////////////////////////////////////////////
	// Identification levels
	localparam logic [2:0] LEVEL_NONE  = 3'h0;
	localparam logic [2:0] LEVEL_LINE  = 3'h1;
	localparam logic [2:0] LEVEL_RX    = 3'h2;
	localparam logic [2:0] LEVEL_TX    = 3'h3;
	localparam logic [2:0] LEVEL_MODEM = 3'h4;

	////////////////////////////////////////////////////////////////////////
	// Serial timing in 16x ticks
	localparam logic [4:0] TICKS_PER_BIT = 5'h10;
	// Start centre at seven and a half ticks, held in half ticks
	localparam int unsigned START_HALF_TICKS = 15;
	localparam logic [4:0]  START_CHECK_TICKS =
		5'((START_HALF_TICKS + 1) / 2);
	localparam logic [3:0]  DATA_BITS  = 4'h8;
	localparam logic [3:0]  FRAME_BITS = 4'hA;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b11,
		RX_STOP  = 2'b10
	} rx_state_type;

	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} tx_state_type;

endpackage

/* rtl/rx_front.sv */
// Receive front end: start-bit validation and 8N1 character assembly.
// Assumes serial_in synchronous to mclk and a one-cycle 16x tick.
module rx_front (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         baud_tick,
	input  wire logic         serial_in,
	output logic              char_valid,
	output logic [7:0]        char_data,
	output logic              framing_error,
	output logic              break_seen
);
	import uart_pkg::*;

	typedef struct packed {
		uart_pkg::rx_state_type state;
		logic [4:0] tick_cnt;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic       prev_in;
		logic       char_valid;
		logic [7:0] char_data;
		logic       framing_error;
		logic       break_seen;
	} rx_regs_type;

	rx_regs_type s;
	rx_regs_type next_s;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		next_s.char_valid = 1'b0;
		next_s.prev_in = serial_in;
		case (s.state)
			RX_IDLE: begin
				if (s.prev_in && !serial_in) begin
					next_s.state = RX_START;
					next_s.tick_cnt = 5'h00;
				end
			end
			RX_START: begin
				if (baud_tick) begin
					next_s.tick_cnt = s.tick_cnt + 5'h01;
					if (s.tick_cnt == START_CHECK_TICKS - 5'h01) begin
						next_s.tick_cnt = 5'h00;
						next_s.bit_cnt = 4'h0;
						// False start drops back without a character
						next_s.state = serial_in ? RX_IDLE : RX_DATA;
					end
				end
			end
			RX_DATA: begin
				if (baud_tick) begin
					next_s.tick_cnt = s.tick_cnt + 5'h01;
					if (s.tick_cnt == TICKS_PER_BIT - 5'h01) begin
						next_s.tick_cnt = 5'h00;
						next_s.shift = {serial_in, s.shift[7:1]};
						next_s.bit_cnt = s.bit_cnt + 4'h1;
						if (s.bit_cnt == DATA_BITS - 4'h1) begin
							next_s.state = RX_STOP;
						end
					end
				end
			end
			RX_STOP: begin
				if (baud_tick) begin
					next_s.tick_cnt = s.tick_cnt + 5'h01;
					if (s.tick_cnt == TICKS_PER_BIT - 5'h01) begin
						next_s.char_valid = 1'b1;
						next_s.char_data = s.shift;
						next_s.framing_error = !serial_in;
						next_s.break_seen = !serial_in &&
							(s.shift == 8'h00);
						next_s.state = RX_IDLE;
					end
				end
			end
			default: next_s.state = RX_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{state: RX_IDLE, prev_in: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign char_valid    = s.char_valid;
	assign char_data     = s.char_data;
	assign framing_error = s.framing_error;
	assign break_seen    = s.break_seen;

endmodule

/* rtl/tx_shift.sv */
// Transmit shift register: sends one 8N1 frame per load.
// Assumes load only while ready is high and a one-cycle 16x tick.
module tx_shift (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         baud_tick,
	input  wire logic         load,
	input  wire logic [7:0]   load_data,
	output logic              ready,
	output logic              serial_out
);
	import uart_pkg::*;

	typedef struct packed {
		uart_pkg::tx_state_type state;
		logic [9:0] shift;
		logic [4:0] tick_cnt;
		logic [3:0] bit_cnt;
		logic       ready;
		logic       serial_out;
	} tx_regs_type;

	tx_regs_type s;
	tx_regs_type next_s;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		case (s.state)
			TX_IDLE: begin
				if (load) begin
					// Stop bit, data LSB first, start bit
					next_s.shift = {1'b1, load_data, 1'b0};
					next_s.tick_cnt = 5'h00;
					next_s.bit_cnt = 4'h0;
					next_s.state = TX_SEND;
				end
			end
			TX_SEND: begin
				if (baud_tick) begin
					next_s.tick_cnt = s.tick_cnt + 5'h01;
					if (s.tick_cnt == TICKS_PER_BIT - 5'h01) begin
						next_s.tick_cnt = 5'h00;
						next_s.shift = {1'b1, s.shift[9:1]};
						next_s.bit_cnt = s.bit_cnt + 4'h1;
						if (s.bit_cnt == FRAME_BITS - 4'h1) begin
							next_s.state = TX_IDLE;
						end
					end
				end
			end
			default: next_s.state = TX_IDLE;
		endcase
		next_s.ready = (next_s.state == TX_IDLE);
		next_s.serial_out = (next_s.state == TX_IDLE) ? 1'b1 :
			next_s.shift[0];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{state: TX_IDLE, ready: 1'b1, serial_out: 1'b1,
				default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign ready      = s.ready;
	assign serial_out = s.serial_out;

endmodule

/* rtl/uart_channel.sv */
// One UART channel: holding registers, receive queue, interrupt enable.
// Assumes bus strobes synchronous to mclk and a 16x tick from outside;
// line control, FIFO control and modem logic live elsewhere.
//
// What this block does
// - Host write moves byte toward transmit shifter
// - Holding-empty flag set when last queued byte moves to shifter
// - Receive read returns and removes oldest character
// - Falling input edge starts 16x start counter
// - Sample at 8 ticks (7.5 rounded up); reject high start
// - Receive errors and break posted in line state
// - Enable bits 7:4 unused, read zero
// - Bit 3 gates modem change interrupt
// - Bit 2 gates line error interrupt
// - Non-FIFO transmit interrupt tracks holding empty
// - FIFO transmit interrupt needs queue fully empty
// - Non-FIFO receive interrupt while holding has data
// - FIFO receive interrupt at trigger fill level
// - Enable bits reset to zero, one enables
// - Enables gate sources onto channel interrupt pin
// - Transmit is level 3, receive level 2
// - Access only with chip select; latch bit low except for line state
module uart_channel (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         cs_n,
	input  wire logic [2:0]   addr,
	input  wire logic         rd_n,
	input  wire logic         wr_n,
	input  wire logic [7:0]   data_in,
	output logic [7:0]        data_out,
	output logic              data_oe,
	input  wire logic         divisor_latch_sel,
	input  wire logic         fifo_mode,
	input  wire logic [4:0]   rx_trigger_count,
	input  wire logic [3:0]   modem_change,
	input  wire logic         baud16_tick,
	input  wire logic         serial_in,
	output logic              serial_out,
	output logic              channel_irq,
	output logic [2:0]        irq_level,
	output logic [7:0]        line_state,
	output logic              transmit_ready,
	output logic              receive_ready
);
	import uart_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Reset release

	logic rst_meta;
	logic rst_sync_n;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Queue capacity: the whole FIFO, or a single holding register
	function automatic logic [4:0] capacity(input logic fifo_on);
		capacity = fifo_on ? 5'(FIFO_DEPTH) : 5'h01;
	endfunction

	function automatic logic [4:0] step(input logic [4:0] cnt,
		input logic inc, input logic dec);
		step = cnt + {4'h0, inc} - {4'h0, dec};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [7:0]                  irq_enable_reg;
		logic [FIFO_DEPTH-1:0][7:0]  rx_mem;
		logic [PTR_W-1:0]            rx_wp;
		logic [PTR_W-1:0]            rx_rp;
		logic [CNT_W-1:0]            rx_cnt;
		logic [FIFO_DEPTH-1:0][7:0]  tx_mem;
		logic [PTR_W-1:0]            tx_wp;
		logic [PTR_W-1:0]            tx_rp;
		logic [CNT_W-1:0]            tx_cnt;
		logic [3:0]                  line_err;
		logic                        fifo_prev;
		logic                        rd_prev_n;
		logic                        wr_prev_n;
		logic [7:0]                  data_out;
		logic                        data_oe;
		logic                        channel_irq;
		logic [2:0]                  irq_level;
		logic [7:0]                  line_state_reg;
		logic                        transmit_ready;
		logic                        receive_ready;
	} chan_regs_type;

	chan_regs_type s;
	chan_regs_type next_s;

	logic       rx_valid;
	logic [7:0] rx_data;
	logic       rx_framing;
	logic       rx_break;
	logic       tx_idle;
	logic       tx_load;

	////////////////////////////////////////////////////////////////////////
	// Serial ends

	rx_front u_rx (
		.mclk          (mclk),
		.rst_n         (rst_sync_n),
		.baud_tick     (baud16_tick),
		.serial_in     (serial_in),
		.char_valid    (rx_valid),
		.char_data     (rx_data),
		.framing_error (rx_framing),
		.break_seen    (rx_break)
	);

	tx_shift u_tx (
		.mclk       (mclk),
		.rst_n      (rst_sync_n),
		.baud_tick  (baud16_tick),
		.load       (tx_load),
		.load_data  (s.tx_mem[s.tx_rp]),
		.ready      (tx_idle),
		.serial_out (serial_out)
	);

	// Oldest queued byte goes to the shifter as soon as it is idle
	assign tx_load = tx_idle && (s.tx_cnt != 5'h00);

	////////////////////////////////////////////////////////////////////////
	// Register access and queues

	logic       gen_set;
	logic       rd_start;
	logic       wr_start;
	logic [4:0] limit;
	logic       tx_push;
	logic       rx_push;
	logic       rx_pop;
	logic       overrun;
	logic       ls_read;
	logic       hold_empty;
	logic       rx_src;
	logic       tx_src;
	logic       line_src;
	logic       modem_src;
	logic [3:0] pending;
	logic [3:0] err_set;

	always_comb begin
		next_s = s;
		next_s.rd_prev_n = rd_n;
		next_s.wr_prev_n = wr_n;
		next_s.fifo_prev = fifo_mode;

		// Strobes act on their leading edge, once per access
		rd_start = s.rd_prev_n && !rd_n && !cs_n;
		wr_start = s.wr_prev_n && !wr_n && !cs_n;
		gen_set = !divisor_latch_sel;
		limit = capacity(fifo_mode);

		tx_push = wr_start && gen_set && (addr == ADDR_HOLDING) &&
			(s.tx_cnt < limit);
		rx_pop = rd_start && gen_set && (addr == ADDR_HOLDING) &&
			(s.rx_cnt != 5'h00);
		rx_push = rx_valid && (s.rx_cnt < limit);
		overrun = rx_valid && !(s.rx_cnt < limit);
		ls_read = rd_start && (addr == ADDR_LINE_STATE);

		// Transmit queue
		if (tx_push) begin
			next_s.tx_mem[s.tx_wp] = data_in;
			next_s.tx_wp = s.tx_wp + 4'h1;
		end
		if (tx_load) begin
			next_s.tx_rp = s.tx_rp + 4'h1;
		end
		next_s.tx_cnt = step(s.tx_cnt, tx_push, tx_load);

		// Receive queue
		if (rx_push) begin
			next_s.rx_mem[s.rx_wp] = rx_data;
			next_s.rx_wp = s.rx_wp + 4'h1;
		end
		if (rx_pop) begin
			next_s.rx_rp = s.rx_rp + 4'h1;
		end
		next_s.rx_cnt = step(s.rx_cnt, rx_push, rx_pop);

		// A mode change discards queued data on both sides
		if (fifo_mode != s.fifo_prev) begin
			next_s.tx_wp = '0;
			next_s.tx_rp = '0;
			next_s.tx_cnt = '0;
			next_s.rx_wp = '0;
			next_s.rx_rp = '0;
			next_s.rx_cnt = '0;
		end

		// Error bits: a new error wins over the clear by a status read
		err_set = 4'h0;
		err_set[ERR_OVERRUN] = overrun;
		err_set[ERR_FRAMING] = rx_valid && rx_framing;
		err_set[ERR_BREAK] = rx_valid && rx_break;
		next_s.line_err = (s.line_err & ~{4{ls_read}}) | err_set;

		// Enable register write
		if (wr_start && gen_set && (addr == ADDR_IRQ_ENABLE)) begin
			next_s.irq_enable_reg = data_in & IRQ_ENABLE_MASK;
		end

		// Read data is captured at the start of the read strobe
		if (cs_n || rd_n) begin
			next_s.data_oe = 1'b0;
		end
		if (rd_start) begin
			if (gen_set && (addr == ADDR_HOLDING)) begin
				next_s.data_out = s.rx_mem[s.rx_rp];
				next_s.data_oe = 1'b1;
			end else if (gen_set && (addr == ADDR_IRQ_ENABLE)) begin
				next_s.data_out = s.irq_enable_reg;
				next_s.data_oe = 1'b1;
			end else if (addr == ADDR_LINE_STATE) begin
				next_s.data_out = s.line_state_reg;
				next_s.data_oe = 1'b1;
			end else begin
				next_s.data_oe = 1'b0;
			end
		end

		// Interrupt sources from the state being entered
		hold_empty = (next_s.tx_cnt == 5'h00);
		rx_src = fifo_mode ?
			(next_s.rx_cnt >= rx_trigger_count) &&
			(next_s.rx_cnt != 5'h00) :
			(next_s.rx_cnt != 5'h00);
		// Whole queue empty covers holding register and FIFO alike
		tx_src = hold_empty;
		line_src = |next_s.line_err;
		modem_src = |modem_change;
		pending = 4'h0;
		pending[IE_RX] = rx_src;
		pending[IE_TX] = tx_src;
		pending[IE_LINE] = line_src;
		pending[IE_MODEM] = modem_src;
		pending = pending & next_s.irq_enable_reg[3:0];
		next_s.channel_irq = |pending;

		if (pending[IE_LINE]) begin
			next_s.irq_level = LEVEL_LINE;
		end else if (pending[IE_RX]) begin
			next_s.irq_level = LEVEL_RX;
		end else if (pending[IE_TX]) begin
			next_s.irq_level = LEVEL_TX;
		end else if (pending[IE_MODEM]) begin
			next_s.irq_level = LEVEL_MODEM;
		end else begin
			next_s.irq_level = LEVEL_NONE;
		end

		next_s.line_state_reg = 8'h00;
		next_s.line_state_reg[LS_DATA_READY] = (next_s.rx_cnt != 5'h00);
		next_s.line_state_reg[LS_ERR_MSB:LS_ERR_LSB] =
			next_s.line_err;
		next_s.line_state_reg[LS_HOLD_EMPTY] = hold_empty;
		next_s.line_state_reg[LS_TX_IDLE] = hold_empty && tx_idle &&
			!tx_load;
		next_s.line_state_reg[LS_FIFO_ERR] = 1'b0;

		next_s.transmit_ready = hold_empty;
		next_s.receive_ready = (next_s.rx_cnt != 5'h00);
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s <= '{irq_enable_reg: IRQ_ENABLE_RESET,
				line_state_reg: LINE_STATE_RESET,
				rd_prev_n: 1'b1, wr_prev_n: 1'b1,
				transmit_ready: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign data_out       = s.data_out;
	assign data_oe        = s.data_oe;
	assign channel_irq    = s.channel_irq;
	assign irq_level      = s.irq_level;
	assign line_state     = s.line_state_reg;
	assign transmit_ready = s.transmit_ready;
	assign receive_ready  = s.receive_ready;

endmodule

/* testbench/uart_channel_sva.sv */
// Concurrent checks on the ports of one UART channel.
// Assumes one mclk domain; bound into every uart_channel instance.
module uart_channel_sva
	import uart_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       cs_n,
	input wire logic [2:0] addr,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	input wire logic       divisor_latch_sel,
	input wire logic       fifo_mode,
	input wire logic [3:0] modem_change,
	input wire logic       serial_out,
	input wire logic       channel_irq,
	input wire logic [2:0] irq_level,
	input wire logic [7:0] line_state,
	input wire logic       transmit_ready,
	input wire logic       receive_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	irq_pin_a: assert property (channel_irq == (irq_level != LEVEL_NONE))
		else $error("irq pin disagrees with level");
	tx_level_a: assert property (irq_level == LEVEL_TX |->
		transmit_ready || $past(transmit_ready)) else $error("tx level");
	rx_level_a: assert property (irq_level == LEVEL_RX |->
		receive_ready || $past(receive_ready)) else $error("rx level");
	line_level_a: assert property (irq_level == LEVEL_LINE |->
		|line_state[4:1] || $past(|line_state[4:1])) else $error("line lvl");
	modem_level_a: assert property (irq_level == LEVEL_MODEM |->
		|modem_change || $past(|modem_change)) else $error("modem level");
	read_answer_a: assert property ($fell(rd_n) && !cs_n &&
		(addr == ADDR_LINE_STATE || (!divisor_latch_sel && addr < 3'h2))
		|=> data_oe) else $error("read not answered");
	read_refused_a: assert property ($fell(rd_n) && divisor_latch_sel &&
		addr == ADDR_IRQ_ENABLE && !data_oe |=> !data_oe)
		else $error("latched read answered");
	ier_upper_a: assert property ($fell(rd_n) && !cs_n &&
		!divisor_latch_sel && addr == ADDR_IRQ_ENABLE |=>
		data_out[7:4] == 4'h0) else $error("enable upper bits set");
	tx_start_a: assert property ($fell(wr_n) && !cs_n &&
		!divisor_latch_sel && addr == ADDR_HOLDING && line_state[6]
		|-> ##[1:4] !serial_out) else $error("no start bit");
	hold_empty_a: assert property ($fell(wr_n) && !cs_n &&
		!divisor_latch_sel && addr == ADDR_HOLDING && !fifo_mode &&
		line_state[6] |=> ##[0:4] line_state[5]) else $error("no empty");
	cover property ($rose(channel_irq));
	cover property (irq_level == LEVEL_RX);
	cover property (line_state[3]);
endmodule

bind uart_channel uart_channel_sva u_sva (.mclk, .rst_n, .cs_n, .addr,
	.rd_n, .wr_n, .data_out, .data_oe, .divisor_latch_sel, .fifo_mode,
	.modem_change, .serial_out, .channel_irq, .irq_level, .line_state,
	.transmit_ready, .receive_ready);

/* testbench/host_bus.sv */
// Host processor model on the channel's strobe bus.
// Assumes drive on falling mclk; data_oe marks an answered read.
module host_bus (
	input  wire logic       mclk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	output logic            cs_n,
	output logic [2:0]      addr,
	output logic            rd_n,
	output logic            wr_n,
	output logic [7:0]      data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n = 1'b1;
		addr = 3'h7;
		rd_n = 1'b1;
		wr_n = 1'b1;
		data_in = 8'hFF;
	end
	// Strobe two cycles under chip select, then a gap
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge mclk);
		cs_n = 1'b0;
		addr = a;
		data_in = d;
		wr_n = 1'b0;
		@(negedge mclk);
		@(negedge mclk);
		wr_n = 1'b1;
		cs_n = 1'b1;
		data_in = ~d;
		@(negedge mclk);
	endtask
	// Held until data_oe is seen; refused reads give up after 4 cycles
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		int n;
		n = 0;
		@(negedge mclk);
		cs_n = 1'b0;
		addr = a;
		rd_n = 1'b0;
		do begin
			@(negedge mclk);
			n++;
		end while (data_oe !== 1'b1 && n < 4);
		@(negedge mclk);
		d = data_out;
		rd_n = 1'b1;
		cs_n = 1'b1;
		@(negedge mclk);
	endtask
endmodule

/* testbench/uart_holding_regs_irq_enable_test.sv */
// Self-checking bench for one UART channel.
// Assumes host_bus model and the bound checker; 16x tick every 4 mclk.
module uart_holding_regs_irq_enable_test;
	import uart_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst_n = 1'b0, dls = 1'b0, fifo_mode = 1'b0;
	logic tick = 1'b0, serial_in = 1'b1;
	logic [4:0] trig = 5'h01;
	logic [3:0] modem_change = 4'h0;
	logic cs_n, rd_n, wr_n, data_oe, serial_out, channel_irq;
	logic transmit_ready, receive_ready;
	logic [2:0] addr, irq_level;
	logic [7:0] data_in, data_out, line_state, d;
	logic [1:0] tcnt = 2'h0;
	int miscompares = 0, n_compared = 0, cycles = 0;
	host_bus host (.mclk, .data_out, .data_oe, .cs_n, .addr, .rd_n,
		.wr_n, .data_in);
	uart_channel dut (.mclk, .rst_n, .cs_n, .addr, .rd_n, .wr_n, .data_in,
		.data_out, .data_oe, .divisor_latch_sel(dls), .fifo_mode,
		.rx_trigger_count(trig), .modem_change, .baud16_tick(tick),
		.serial_in, .serial_out, .channel_irq, .irq_level, .line_state,
		.transmit_ready, .receive_ready);
	initial forever #20 mclk = ~mclk;
	// Tick is launched on the falling edge like every other input
	always @(negedge mclk) begin
		tcnt <= tcnt + 2'h1;
		tick <= (tcnt == 2'h3);
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// One 8N1 frame, 64 mclk per bit, stop level selectable
	task automatic send(input logic [7:0] b, input logic stop);
		serial_in = 1'b0;
		wt(64);
		for (int i = 0; i < 8; i++) begin
			serial_in = b[i];
			wt(64);
		end
		serial_in = stop;
		wt(64);
		serial_in = 1'b1;
		wt(64);
	endtask
	task automatic conclude();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk(line_state, LINE_STATE_RESET);
		host.rd(ADDR_IRQ_ENABLE, d);
		chk(d, IRQ_ENABLE_RESET);
		chk(channel_irq, 1'b0);
	endtask
	task automatic t_ier();
		host.wr(ADDR_IRQ_ENABLE, 8'hFF);
		host.rd(ADDR_IRQ_ENABLE, d);
		chk(d, 8'h0F);
		chk(channel_irq, 1'b1);
		chk(irq_level, LEVEL_TX);
		host.wr(ADDR_IRQ_ENABLE, 8'h08);
		chk(channel_irq, 1'b0);
		modem_change = 4'h2;
		wt(3);
		chk(irq_level, LEVEL_MODEM);
		modem_change = 4'h0;
		host.wr(ADDR_IRQ_ENABLE, 8'h00);
		chk(channel_irq, 1'b0);
	endtask
	task automatic t_latch();
		dls = 1'b1;
		host.wr(ADDR_IRQ_ENABLE, 8'h01);
		host.rd(ADDR_IRQ_ENABLE, d);
		dls = 1'b0;
		host.rd(ADDR_IRQ_ENABLE, d);
		chk(d, 8'h00);
	endtask
	task automatic t_tx();
		logic [7:0] b;
		int n;
		n = 0;
		host.wr(ADDR_HOLDING, 8'hA5);
		while (serial_out !== 1'b0 && n < 300) begin
			wt(1);
			n++;
		end
		wt(32);
		chk(serial_out, 1'b0);
		for (int i = 0; i < 8; i++) begin
			wt(64);
			b[i] = serial_out;
		end
		chk(b, 8'hA5);
		chk(line_state[5], 1'b1);
		wt(128);
		chk(line_state, LINE_STATE_RESET);
		chk(transmit_ready, 1'b1);
	endtask
	task automatic t_rx();
		host.wr(ADDR_IRQ_ENABLE, 8'h05);
		send(8'h3C, 1'b1);
		chk(irq_level, LEVEL_RX);
		host.rd(ADDR_HOLDING, d);
		chk(d, 8'h3C);
		wt(2);
		chk(channel_irq, 1'b0);
		serial_in = 1'b0;
		wt(12);
		serial_in = 1'b1;
		wt(800);
		chk(receive_ready, 1'b0);
		send(8'h55, 1'b0);
		chk(line_state[3], 1'b1);
		chk(irq_level, LEVEL_LINE);
		// Break while the holding register is full: break and overrun
		send(8'h00, 1'b0);
		chk(line_state[4], 1'b1);
		host.rd(ADDR_LINE_STATE, d);
		chk(d[4:1], 4'hD);
		chk(line_state[4:1], 4'h0);
		host.rd(ADDR_HOLDING, d);
		chk(d, 8'h55);
		wt(2);
		chk(channel_irq, 1'b0);
	endtask
	task automatic t_fifo();
		fifo_mode = 1'b1;
		trig = 5'h02;
		host.wr(ADDR_IRQ_ENABLE, 8'h01);
		send(8'h11, 1'b1);
		chk(channel_irq, 1'b0);
		send(8'h22, 1'b1);
		chk(channel_irq, 1'b1);
		host.rd(ADDR_HOLDING, d);
		chk(d, 8'h11);
		wt(2);
		chk(channel_irq, 1'b0);
		host.wr(ADDR_IRQ_ENABLE, 8'h02);
		chk(irq_level, LEVEL_TX);
	endtask
	initial begin
		wt(20);
		rst_n = 1'b1;
		wt(4);
		t_reset();
		t_ier();
		t_latch();
		t_tx();
		t_rx();
		t_fifo();
		conclude();
	end
endmodule
